//--- hdl/fbp_defines.vh
// fbp_defines.vh: constants for the flash block protection logic
// assumes inclusion by bare name from the design files
`ifndef FBP_DEFINES_VH
`define FBP_DEFINES_VH
// ***************************************************************
// register byte addresses
// ***************************************************************
`define FBP_CTRL_OFS      12'h000
`define FBP_PROT_OFS      12'h004
`define FBP_STAT_OFS      12'h008
`define FBP_ADDR_OFS      12'h00c
`define FBP_WDATA_OFS     12'h010
// ***************************************************************
// control register fields
// ***************************************************************
`define FBP_CTRL_PGM      0
`define FBP_CTRL_ERASE    1
`define FBP_CTRL_MASS     2
`define FBP_CTRL_HIGH_VOLTAGE_ENABLE     3
// ***************************************************************
// status register fields
// ***************************************************************
`define FBP_ST_PROT       0
`define FBP_ST_ANY        1
`define FBP_ST_VTST       2
`define FBP_ST_SEQ        3
`define FBP_ST_STBY       4
`define FBP_ST_HVREF      5
// ***************************************************************
// addresses and values
// ***************************************************************
`define FBP_TOP_ADDR      16'hffff
`define FBP_PROT_ADDR     16'hffbe
`define FBP_ERASED        8'hff
`define FBP_FACTORY       8'hff
`define FBP_FLASH_LO      16'hee00
`endif

//--- hdl/fbp_range.v
// fbp_range.v: derives the protect start address and checks a target
// assumes a stable protect byte and target address from the caller
`timescale 1ns/10ps
`include "fbp_defines.vh"
module fbp_range
(
  prot_byte,
  target,
  start_addr,
  is_prot,
  any_prot
);
  input  wire [7:0]  prot_byte;
  input  wire [15:0] target;
  output wire [15:0] start_addr;
  output wire        is_prot;
  output wire        any_prot;

  // start address: byte at [13:6], top bits ones, low bits zeros
  // address formation
  assign start_addr = {2'b11, prot_byte, 6'h00};
  // compare ge start; erased byte opens all
  assign any_prot   = (prot_byte != `FBP_ERASED);
  // low values give a start below flash, so all is covered
  assign is_prot    = any_prot && (target >= start_addr);
endmodule // fbp_range

//--- hdl/fbp_top.v
// fbp_top.v: flash block protection with its control register
// assumes one AHB-Lite master, hclk at 50 MHz, flash array outside
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "fbp_defines.vh"
// Summary of operation
// - protection runs from start up to top
// - no high voltage on protected target
// - values up to b8 protect everything
// - erased value ff leaves flash open
// - non-ff value locks block and protect byte
// - mass erase off while anything protected
// - protect byte changes only with test voltage
// - protect byte held in flash, programmed or erased only
// - start address from byte at bits 13:6
// - value fe protects top region and vectors
// - protect byte survives reset, factory all ones
// - wait or stop aborts program or erase
// - standby holds select, mass and high voltage controls inactive
// - wait or stop in read mode harmless
// - high voltage only after select and sequence
// - program and erase selects are interlocked
module fbp_top
(
  hclk,
  hresetn,
  clk_en,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  test_high_voltage,
  halt_mode,
  arr_pgm,
  arr_erase,
  arr_mass,
  arr_high_voltage_enable,
  arr_addr,
  arr_wdata,
  arr_wr
);
  input  wire        hclk;
  input  wire        hresetn;
  input  wire        clk_en;
  input  wire        hsel;
  input  wire [31:0] haddr;
  input  wire [1:0]  htrans;
  input  wire        hwrite;
  input  wire [2:0]  hsize;
  input  wire [31:0] hwdata;
  input  wire        hready;
  output wire        hreadyout;
  output wire        hresp;
  output reg  [31:0] hrdata;
  input  wire        test_high_voltage;
  input  wire        halt_mode;
  output wire        arr_pgm;
  output wire        arr_erase;
  output wire        arr_mass;
  output wire        arr_high_voltage_enable;
  output reg  [15:0] arr_addr;
  output reg  [7:0]  arr_wdata;
  output reg         arr_wr;

  // ***************************************************************
  // state
  // ***************************************************************
  reg        pgm_ff;
  reg        erase_ff;
  reg        mass_ff;
  reg        high_voltage_enable_ff;
  reg        prot_read_ff;      // protect register read since select
  reg        latched_ff;        // target address latched
  reg        standby_ff;
  reg  [7:0] prot_byte_ff;      // models the flash-resident byte
  reg  [15:0] tgt_ff;
  reg        ph_wr_ff;
  reg        ph_rd_ff;
  reg  [11:0] ph_addr_ff;
  reg        prot_hit_ff;       // last control write asked for high voltage, refused
  reg        nxt_pgm;
  reg        nxt_erase;
  reg        nxt_mass;
  reg        nxt_high_voltage_enable;

  wire [15:0] start_addr;
  wire        tgt_prot;
  wire        any_prot;
  wire        tgt_is_byte;
  wire        addr_phase;
  wire        ctrl_wr;
  wire        seq_ok;
  wire        hv_allowed;

  fbp_range u_range
  (
    .prot_byte  (prot_byte_ff),
    .target     (tgt_ff),
    .start_addr (start_addr),
    .is_prot    (tgt_prot),
    .any_prot   (any_prot)
  );

  // decoding used for both reads and writes
  function is_reg;
    input [11:0] a;
    input [11:0] ofs;
    begin
      is_reg = (a == ofs);
    end
  endfunction

  assign hreadyout   = 1'b1;    // zero wait states
  assign hresp       = 1'b0;
  assign addr_phase  = hsel && hready && htrans[1];
  assign ctrl_wr     = ph_wr_ff && is_reg(ph_addr_ff, `FBP_CTRL_OFS);
  assign tgt_is_byte = (tgt_ff == `FBP_PROT_ADDR);

  // sequence: select set, protect reg read, target latched
  // the read is tracked because the device depends on it
  assign seq_ok = (pgm_ff || erase_ff) && prot_read_ff && latched_ff;

  // protected block and protect byte locked once non-ff
  // mass erase off while anything is protected
  // protect byte needs test voltage, which also lifts its lock
  assign hv_allowed = seq_ok &&
                      !(tgt_is_byte && !test_high_voltage) &&
                      (mass_ff ? !any_prot : (tgt_is_byte || !tgt_prot));

  // ***************************************************************
  // bus address phase capture
  // ***************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_ff   <= 1'b0;
      ph_rd_ff   <= 1'b0;
      ph_addr_ff <= 12'h000;
    end
    else if (clk_en)
    begin
      ph_wr_ff   <= addr_phase && hwrite;
      ph_rd_ff   <= addr_phase && !hwrite;
      ph_addr_ff <= haddr[11:0];
    end
  end

  // ***************************************************************
  // control register next value
  // ***************************************************************
  always @*
  begin
    nxt_pgm   = pgm_ff;
    nxt_erase = erase_ff;
    nxt_mass  = mass_ff;
    nxt_high_voltage_enable  = high_voltage_enable_ff;
    if (ctrl_wr)
    begin
      // a write asking for both keeps neither new
      if (!(hwdata[`FBP_CTRL_PGM] && hwdata[`FBP_CTRL_ERASE]))
      begin
        nxt_pgm   = hwdata[`FBP_CTRL_PGM] && !erase_ff;
        nxt_erase = hwdata[`FBP_CTRL_ERASE] && !pgm_ff;
      end
      nxt_mass = hwdata[`FBP_CTRL_MASS];
      // high voltage set only when allowed; clear always
      if (!hwdata[`FBP_CTRL_HIGH_VOLTAGE_ENABLE])
        nxt_high_voltage_enable = 1'b0;
      else if (hv_allowed)
        nxt_high_voltage_enable = 1'b1;
    end
    // halt during an operation aborts it
    if (halt_mode && (pgm_ff || erase_ff || high_voltage_enable_ff))
    begin
      nxt_pgm   = 1'b0;
      nxt_erase = 1'b0;
      nxt_mass  = 1'b0;
      nxt_high_voltage_enable  = 1'b0;
    end
  end

  // ***************************************************************
  // control, sequence and array write logic
  // ***************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pgm_ff       <= 1'b0;
      erase_ff     <= 1'b0;
      mass_ff      <= 1'b0;
      high_voltage_enable_ff      <= 1'b0;
      prot_read_ff <= 1'b0;
      latched_ff   <= 1'b0;
      standby_ff   <= 1'b0;
      tgt_ff       <= 16'h0000;
      prot_hit_ff  <= 1'b0;
      arr_addr     <= 16'h0000;
      arr_wdata    <= 8'h00;
      arr_wr       <= 1'b0;
    end
    else if (clk_en)
    begin
      pgm_ff   <= nxt_pgm;
      erase_ff <= nxt_erase;
      mass_ff  <= nxt_mass;
      high_voltage_enable_ff  <= nxt_high_voltage_enable;
      arr_wr   <= 1'b0;
      // standby after abort; left on the next new select
      if (halt_mode && (pgm_ff || erase_ff || high_voltage_enable_ff))
        standby_ff <= 1'b1;
      else if (nxt_pgm || nxt_erase)
        standby_ff <= 1'b0;
      if (ctrl_wr)
        prot_hit_ff <= hwdata[`FBP_CTRL_HIGH_VOLTAGE_ENABLE] && !hv_allowed;
      // sequence tracking restarts whenever the selects drop
      if (!nxt_pgm && !nxt_erase)
      begin
        prot_read_ff <= 1'b0;
        latched_ff   <= 1'b0;
      end
      else
      begin
        if (ph_rd_ff && is_reg(ph_addr_ff, `FBP_PROT_OFS))
          prot_read_ff <= 1'b1;
        // target address write latches the array address
        if (ph_wr_ff && is_reg(ph_addr_ff, `FBP_ADDR_OFS) && !high_voltage_enable_ff)
        begin
          tgt_ff     <= hwdata[15:0];
          latched_ff <= prot_read_ff;
        end
      end
      // data reach the array only under program plus voltage
      if (ph_wr_ff && is_reg(ph_addr_ff, `FBP_WDATA_OFS) &&
          pgm_ff && high_voltage_enable_ff)
      begin
        arr_addr  <= tgt_ff;
        arr_wdata <= hwdata[7:0];
        arr_wr    <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // protect byte image, not reset
  // ***************************************************************
  // no reset term: value survives reset, factory all ones
  initial prot_byte_ff = `FBP_FACTORY;
  always @(posedge hclk)
  begin
    if (clk_en)
    begin
      // changed only by a programmed flash write to its slot or by the erase below
      if (arr_wr && arr_addr == `FBP_PROT_ADDR)
        prot_byte_ff <= prot_byte_ff & arr_wdata;
      // erase aimed at the protect byte address restores erased value
      else if (erase_ff && high_voltage_enable_ff && !pgm_ff && ctrl_wr &&
               !hwdata[`FBP_CTRL_ERASE] && tgt_is_byte)
        prot_byte_ff <= `FBP_ERASED;
    end
  end

  // ***************************************************************
  // array control outputs
  // ***************************************************************
  // standby forces the select, mass and high voltage controls inactive; arr_wr is not gated
  // halt in read mode touches nothing
  assign arr_pgm   = pgm_ff && !standby_ff;
  assign arr_erase = erase_ff && !standby_ff;
  assign arr_mass  = mass_ff && erase_ff && !standby_ff;
  assign arr_high_voltage_enable  = high_voltage_enable_ff && !standby_ff;

  // ***************************************************************
  // read data
  // ***************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (clk_en && addr_phase && !hwrite)
    begin
      hrdata <= 32'h00000000;   // unmapped reads as zero
      if (is_reg(haddr[11:0], `FBP_CTRL_OFS))
        hrdata[3:0] <= {high_voltage_enable_ff, mass_ff, erase_ff, pgm_ff};
      if (is_reg(haddr[11:0], `FBP_PROT_OFS))
        hrdata[7:0] <= prot_byte_ff;
      if (is_reg(haddr[11:0], `FBP_STAT_OFS))
        hrdata[5:0] <= {prot_hit_ff, standby_ff, seq_ok,
                        test_high_voltage, any_prot, tgt_prot};
      if (is_reg(haddr[11:0], `FBP_ADDR_OFS))
        hrdata[31:0] <= {start_addr, tgt_ff};
    end
  end
endmodule // fbp_top

//--- tb/fbp_top_assertions.sv
// fbp_top_assertions.sv: port checks for the flash protection block
// assumes it is bound onto fbp_top, one clock hclk, reset hresetn
`timescale 1ns/10ps
module fbp_chk
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic halt_mode,
  input wire logic arr_pgm,
  input wire logic arr_erase,
  input wire logic arr_mass,
  input wire logic arr_high_voltage_enable,
  input wire logic arr_wr
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ***************************************************************
  // bus and array control properties
  // ***************************************************************
  property p_ready; hreadyout == 1'b1; endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_lock; !(arr_pgm && arr_erase); endproperty
  property p_hv_sel; $rose(arr_high_voltage_enable) |-> arr_pgm || arr_erase; endproperty
  property p_halt;
    halt_mode && clk_en && (arr_pgm || arr_erase)
      |=> !arr_pgm && !arr_erase && !arr_high_voltage_enable && !arr_mass;
  endproperty
  // the cycle after halt, with both selects low, high voltage and array write must be low
  property p_stby;
    $past(halt_mode) && !arr_pgm && !arr_erase |-> !arr_high_voltage_enable && !arr_wr;
  endproperty
  property p_wr_hv; arr_wr |-> arr_pgm && arr_high_voltage_enable; endproperty
  property p_wr_pulse; arr_wr |=> !arr_wr; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("hresp not okay");
  a_lock: assert property (p_lock) else $error("both selects set");
  a_hv_sel: assert property (p_hv_sel) else $error("hv no select");
  a_halt: assert property (p_halt) else $error("halt no abort");
  a_stby: assert property (p_stby) else $error("standby active");
  a_wr_hv: assert property (p_wr_hv) else $error("write without hv");
  a_wr_pulse: assert property (p_wr_pulse) else $error("long pulse");
  c_wr: cover property (arr_wr);
  c_erase_hv: cover property ($rose(arr_high_voltage_enable) && arr_erase);
  c_halt: cover property (halt_mode && arr_pgm);
endmodule // fbp_chk
bind fbp_top fbp_chk u_chk
(
  .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hresp(hresp),
  .hreadyout(hreadyout), .halt_mode(halt_mode), .arr_pgm(arr_pgm),
  .arr_erase(arr_erase), .arr_mass(arr_mass), .arr_high_voltage_enable(arr_high_voltage_enable),
  .arr_wr(arr_wr)
);

//--- tb/fbp_flash_model.sv
// fbp_flash_model.sv: flash array stand-in that latches each write
// assumes arr_wr is a one-cycle strobe on hclk
`timescale 1ns/10ps
module fbp_flash_model
(
  input  wire logic        hclk,
  input  wire logic        arr_wr,
  input  wire logic [15:0] arr_addr,
  input  wire logic [7:0]  arr_wdata,
  output logic      [15:0] last_addr,
  output logic      [7:0]  last_data
);
  // keep only the latest byte; the bench checks one write at a time
  always @(posedge hclk)
  begin
    if (arr_wr)
    begin
      last_addr <= arr_addr;
      last_data <= arr_wdata;
    end
  end
endmodule // fbp_flash_model

//--- tb/tb_flash_block_protection.sv
// tb_flash_block_protection.sv: register level test of fbp_top
// assumes a zero wait slave and the flash model on the array side
`timescale 1ns/10ps
`include "fbp_defines.vh"
module tb_flash_block_protection;
  logic        hclk, hresetn, clk_en, hsel, hwrite, hready, vtst, halt;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, program_select, ers, mass, high_voltage_enable, wr;
  logic [15:0] aaddr, m_addr;
  logic [7:0]  adata, m_data;
  int          failures, n_compared, cycles;
  fbp_top dut
  (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .test_high_voltage(vtst),
    .halt_mode(halt), .arr_pgm(program_select), .arr_erase(ers), .arr_mass(mass),
    .arr_high_voltage_enable(high_voltage_enable), .arr_addr(aaddr), .arr_wdata(adata), .arr_wr(wr)
  );
  fbp_flash_model u_flash
  (
    .hclk(hclk), .arr_wr(wr), .arr_addr(aaddr), .arr_wdata(adata),
    .last_addr(m_addr), .last_data(m_data)
  );
  assign hready = hreadyout;
  // ***************************************************************
  // bus tasks
  // ***************************************************************
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // full select, read, address, high voltage sequence on one target
  task automatic op(input logic [3:0] s, input logic [15:0] t,
                    input logic ok, input logic [7:0] wd);
    xfer(1, `FBP_CTRL_OFS, {28'h0, s});
    xfer(0, `FBP_PROT_OFS, 0);
    xfer(1, `FBP_ADDR_OFS, {16'h0, t});
    xfer(1, `FBP_CTRL_OFS, {28'h0, s | 4'h8});
    xfer(0, `FBP_CTRL_OFS, 0);
    chk(q[3:0], ok ? s | 4'h8 : s);
    if (ok && s == 4'h1)
      xfer(1, `FBP_WDATA_OFS, {24'h0, wd});
    xfer(1, `FBP_CTRL_OFS, 32'h8);
    if (ok && s == 4'h1)
      chk({m_addr, m_data}, {t, wd});
    xfer(1, `FBP_CTRL_OFS, 0);
  endtask
  task automatic summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    hclk = 0;
    forever #10 hclk = ~hclk;
  end
  // hang guard; the full run needs well under a thousand cycles
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      summarize();
    end
  end
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    {hresetn, hsel, hwrite, vtst, halt, htrans, haddr, hwdata} = 0;
    clk_en = 1;
    hsize = 3'b010;
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    xfer(0, `FBP_PROT_OFS, 0);
    chk(q[7:0], `FBP_FACTORY);
    xfer(0, `FBP_STAT_OFS, 0);
    chk(q[1], 0);
    // a write while the clock enable is low must be lost
    clk_en <= 0;
    xfer(1, `FBP_CTRL_OFS, 32'h1);
    clk_en <= 1;
    xfer(0, `FBP_CTRL_OFS, 0);
    chk(q[3:0], 0); // clock enable freeze
    xfer(1, `FBP_CTRL_OFS, 32'h3);
    xfer(0, `FBP_CTRL_OFS, 0);
    chk(q[3:0], 0);
    xfer(1, `FBP_CTRL_OFS, 32'h1);
    xfer(1, `FBP_CTRL_OFS, 32'h9);
    xfer(0, `FBP_CTRL_OFS, 0);
    chk(q[3:0], 1);
    xfer(1, `FBP_CTRL_OFS, 0);
    op(4'h1, 16'hee00, 1, 8'h5a);
    op(4'h6, 16'hee00, 1, 0);
    op(4'h1, 16'hee40, 1, 0);
    xfer(1, `FBP_CTRL_OFS, 32'h1);
    xfer(0, `FBP_PROT_OFS, 0);
    xfer(1, `FBP_ADDR_OFS, 32'hee40);
    xfer(1, `FBP_CTRL_OFS, 32'h9);
    halt <= 1;
    @(posedge hclk);
    halt <= 0;
    @(posedge hclk);
    chk({program_select, high_voltage_enable, mass}, 0);
    xfer(0, `FBP_STAT_OFS, 0);
    chk(q[4], 1);
    halt <= 1;
    @(posedge hclk);
    halt <= 0;
    op(4'h1, 16'hee80, 1, 8'h11);
    op(4'h1, `FBP_PROT_ADDR, 0, 0);
    vtst <= 1;
    op(4'h1, `FBP_PROT_ADDR, 1, 8'hfe);
    vtst <= 0;
    xfer(0, `FBP_PROT_OFS, 0);
    chk(q[7:0], 8'hfe);
    // the target is only latched while a select is set
    xfer(1, `FBP_CTRL_OFS, 32'h1);
    xfer(1, `FBP_ADDR_OFS, 32'hff7f);
    xfer(0, `FBP_ADDR_OFS, 0);
    chk(q, 32'hff80ff7f);
    op(4'h1, 16'hff7f, 1, 8'h33);
    op(4'h1, 16'hff80, 0, 0);
    op(4'h2, `FBP_TOP_ADDR, 0, 0);
    op(4'h6, 16'hee00, 0, 0);
    op(4'h1, `FBP_PROT_ADDR, 0, 0);
    vtst <= 1;
    op(4'h1, `FBP_PROT_ADDR, 1, 8'hb8);
    vtst <= 0;
    op(4'h1, `FBP_FLASH_LO, 0, 0);
    hresetn <= 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    xfer(0, `FBP_PROT_OFS, 0);
    chk(q[7:0], 8'hb8);
    // erasing the protect byte under test voltage reopens the array
    vtst <= 1;
    op(4'h2, `FBP_PROT_ADDR, 1, 0);
    vtst <= 0;
    xfer(0, `FBP_PROT_OFS, 0);
    chk(q[7:0], `FBP_ERASED);
    summarize();
  end
endmodule // tb_flash_block_protection
